// File: npp_pkg.sv
package npp_pkg;

  // ---------------------------------------------------------------
  // register word indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_REVISION = 16'h8005;
  localparam logic [15:0] OFS_PART = 16'h8006;
  localparam logic [15:0] OFS_PARTITION_CFG = 16'h800A;
  localparam logic [15:0] OFS_CODE_PROTECT_CFG = 16'h800B;
  localparam logic [15:0] OFS_CTRL = 16'h8010;
  localparam logic [15:0] OFS_STATUS = 16'h8011;

  // ---------------------------------------------------------------
  // nonvolatile address map
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_SPACE_LO = 16'h8007;
  localparam logic [15:0] CFG_SPACE_HI = 16'h800B;
  localparam logic [15:0] EE_SPACE_LO = 16'hF000;
  localparam logic [15:0] EE_SPACE_HI = 16'hF0FF;
  localparam int SAF_WORDS = 128;
  localparam int PC_W = 15;
  localparam logic [14:0] RESET_VECTOR = 15'h0000;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;

  // boot region end address per size code
  localparam logic [15:0] BOOT_END_111 = 16'h01FF;
  localparam logic [15:0] BOOT_END_110 = 16'h03FF;
  localparam logic [15:0] BOOT_END_101 = 16'h07FF;
  localparam logic [15:0] BOOT_END_100 = 16'h0FFF;
  localparam logic [15:0] BOOT_END_011 = 16'h1FFF;
  localparam logic [15:0] BOOT_END_LOW = 16'h3FFF;

  // ---------------------------------------------------------------
  // reset values and identity layout
  // ---------------------------------------------------------------
  localparam logic [15:0] PARTITION_CFG_RST = 16'h2F9F;
  localparam logic [1:0] CODE_PROTECT_RST = 2'h3;
  localparam logic [1:0] PART_RSV_BITS = 2'h3;
  localparam logic [1:0] REV_RSV_BITS = 2'h2;
  localparam int STAT_LOADED = 0;
  localparam int STAT_WRITE_ERROR = 1;
  localparam int STAT_SAF_ACTIVE = 2;
  localparam int STAT_BOOT_ACTIVE = 3;
  localparam int STAT_EXEC_VIOL = 4;
  localparam int STAT_BOOT_END_LSB = 16;
  localparam int CTRL_BULK_ERASE = 0;

  // partition and write-lock configuration word
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic low_voltage_programming_enable;
    logic rsv_12;
    logic storage_area_write_lock;
    logic eeprom_write_lock;
    logic config_write_lock;
    logic boot_region_write_lock;
    logic application_region_write_lock;
    logic [1:0] rsv_mid;
    logic storage_area_enable_n;
    logic boot_region_enable_n;
    logic [2:0] boot_region_size;
  } npp_partition_s;

  // code protection word
  typedef struct packed {
    logic eeprom_read_guard;
    logic program_flash_read_guard;
  } npp_guard_s;

  typedef enum logic [2:0] {
    RGN_APP,
    RGN_BOOT,
    RGN_SAF,
    RGN_CFG,
    RGN_EE,
    RGN_NONE
  } npp_region_e;

  typedef enum logic {
    ST_LOAD,
    ST_RUN
  } npp_state_e;

endpackage

// File: npp_config_top.sv
`timescale 1ns/1ps
// How it works
// - storage area write lock low blocks storage writes, only while storage area enabled.
// - eeprom write lock low blocks data eeprom writes.
// - config write lock low blocks writes to configuration words.
// - boot write lock low blocks boot writes, only while boot region enabled.
// - application write lock low blocks application region writes.
// - storage area enable is active low.
// - boot region enable is active low; disabled means size field ignored.
// - size code picks boot end: 111 01FF, 110 03FF, 101 07FF, 100 0FFF.
// - boot region clamped to half of implemented program memory.
// - a protecting lock value stays until bulk erase.
// - boot size changes only while boot region disabled.
// - clearing low-voltage programming enable refused while programming over that interface.
// - eeprom read guard low enables eeprom code protection.
// - program flash read guard low enables program flash code protection.
// - code protection, once on, cleared only by bulk erase.
// - code protection acts at once; programmer should write it last.
// - part word gives 12-bit part code, bits 13:12 read one.
// - revision word gives major 11:6, minor 5:0, bit 13 one, bit 12 zero.
// - program counter is 15 bits, 32K word space.
// - addresses beyond implemented memory wrap into it.
// - fetch starts at 0000h after reset, interrupts vector to 0004h.
// - enabled storage area is the last 128 words; a fetch from it still goes out and raises exec violation.
// - protected write leaves memory unchanged and sets write error flag.
module npp_config_top #(
  parameter int PROG_WORDS = 8192,
  parameter logic [11:0] PART_CODE = 12'hA5C,    // arbitrary value
  parameter logic [5:0] MAJOR_REV = 6'h01,       // arbitrary value
  parameter logic [5:0] MINOR_REV = 6'h02        // arbitrary value
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // avalon-mm register slave (word addressed)
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // nonvolatile configuration image and programming mode pin
  input wire logic [15:0] nv_partition_image,
  input wire logic [1:0] nv_guard_image,
  input wire logic lvp_programming_pin,
  // memory controller write check
  input wire logic nvm_wr_req,
  input wire logic [15:0] nvm_wr_addr,
  output logic nvm_wr_done,
  output logic nvm_wr_ok,
  output logic write_error_flag,
  // instruction fetch addressing
  input wire logic [14:0] pc_in,
  input wire logic irq_vector_req,
  output logic [14:0] fetch_addr,
  output logic exec_violation,
  // decoded configuration
  output logic storage_area_active,
  output logic boot_region_active,
  output logic [15:0] boot_end_addr,
  output logic program_flash_read_guard,
  output logic eeprom_read_guard,
  output logic config_loaded
);

  localparam logic [15:0] LAST_ADDR = 16'(PROG_WORDS - 1);
  localparam logic [15:0] HALF_END = 16'(PROG_WORDS / 2 - 1);
  localparam logic [15:0] SAF_LO = 16'(PROG_WORDS - npp_pkg::SAF_WORDS);

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic rst_meta_r, rst_n_s;
  logic lvp_meta_r, lvp_mode_r;

  // async assert, sync release
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s <= rst_meta_r;
    end
  end

  // programming-mode pin comes from outside the clock domain
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      lvp_meta_r <= 1'b0;
      lvp_mode_r <= 1'b0;
    end else begin
      lvp_meta_r <= lvp_programming_pin;
      lvp_mode_r <= lvp_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] boot_end_f(input logic [2:0] code);
    logic [15:0] e;
    e = npp_pkg::BOOT_END_LOW;
    unique case (code)
      3'b111: e = npp_pkg::BOOT_END_111;
      3'b110: e = npp_pkg::BOOT_END_110;
      3'b101: e = npp_pkg::BOOT_END_101;
      3'b100: e = npp_pkg::BOOT_END_100;
      3'b011: e = npp_pkg::BOOT_END_011;
      default: e = npp_pkg::BOOT_END_LOW;
    endcase
    return (e > HALF_END) ? HALF_END : e;
  endfunction

  function automatic npp_pkg::npp_region_e region_of(input logic [15:0] a, input npp_pkg::npp_partition_s c,
                                                     input logic [15:0] bend);
    logic [15:0] w;
    w = a & LAST_ADDR;  // program space wraps
    if (!a[15]) begin
      if (!c.boot_region_enable_n && w <= bend)
        return npp_pkg::RGN_BOOT;
      else if (!c.storage_area_enable_n && w >= SAF_LO)
        return npp_pkg::RGN_SAF;
      else
        return npp_pkg::RGN_APP;
    end else if (a >= npp_pkg::CFG_SPACE_LO && a <= npp_pkg::CFG_SPACE_HI)
      return npp_pkg::RGN_CFG;
    else if (a >= npp_pkg::EE_SPACE_LO && a <= npp_pkg::EE_SPACE_HI)
      return npp_pkg::RGN_EE;
    else
      return npp_pkg::RGN_NONE;
  endfunction

  // merge a 16-bit write under its byte lanes
  function automatic logic [15:0] lane_merge(input logic [15:0] cur, input logic [15:0] wd,
                                             input logic [1:0] be);
    return {be[1] ? wd[15:8] : cur[15:8], be[0] ? wd[7:0] : cur[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // avalon handshake: one wait cycle, answer on the second
  // ---------------------------------------------------------------
  logic ack_r;
  logic bus_wr, bus_rd;

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read || avs_write) && !ack_r;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign bus_wr = avs_write && ack_r;
  assign bus_rd = avs_read && !ack_r;

  // ---------------------------------------------------------------
  // configuration words
  // ---------------------------------------------------------------
  npp_pkg::npp_partition_s part_q, part_nxt, part_wd;
  npp_pkg::npp_guard_s guard_q, guard_nxt, guard_wd;
  npp_pkg::npp_state_e state_r;
  logic bulk_erase;
  logic cfg_wr_part, cfg_wr_guard, cfg_refused;

  assign bulk_erase = bus_wr && avs_address == npp_pkg::OFS_CTRL && avs_byteenable[0]
                      && avs_writedata[npp_pkg::CTRL_BULK_ERASE];
  assign cfg_wr_part = bus_wr && avs_address == npp_pkg::OFS_PARTITION_CFG;
  assign cfg_wr_guard = bus_wr && avs_address == npp_pkg::OFS_CODE_PROTECT_CFG;
  assign cfg_refused = (cfg_wr_part || cfg_wr_guard) && !part_q.config_write_lock;
  assign part_wd = lane_merge(part_q, avs_writedata[15:0], avs_byteenable[1:0]);
  assign guard_wd = avs_byteenable[0] ? avs_writedata[1:0] : guard_q;

  // next partition word: locks only move toward protection
  always_comb begin
    part_nxt = part_q;
    part_nxt.storage_area_write_lock = part_q.storage_area_write_lock & part_wd.storage_area_write_lock;
    part_nxt.eeprom_write_lock = part_q.eeprom_write_lock & part_wd.eeprom_write_lock;
    part_nxt.config_write_lock = part_q.config_write_lock & part_wd.config_write_lock;
    part_nxt.boot_region_write_lock = part_q.boot_region_write_lock & part_wd.boot_region_write_lock;
    part_nxt.application_region_write_lock = part_q.application_region_write_lock
                                              & part_wd.application_region_write_lock;
    part_nxt.storage_area_enable_n = part_q.storage_area_enable_n & part_wd.storage_area_enable_n;
    part_nxt.boot_region_enable_n = part_q.boot_region_enable_n & part_wd.boot_region_enable_n;
    // size frozen once boot region is on
    if (part_q.boot_region_enable_n)
      part_nxt.boot_region_size = part_wd.boot_region_size;
    // leaving low-voltage mode from within it is refused
    if (!(lvp_mode_r && !part_wd.low_voltage_programming_enable))
      part_nxt.low_voltage_programming_enable = part_wd.low_voltage_programming_enable;
  end

  // code protection only turns on through a write
  assign guard_nxt = guard_q & guard_wd;

  // load at reset release, then bus writes and bulk erase
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r <= npp_pkg::ST_LOAD;
      part_q <= npp_pkg::PARTITION_CFG_RST;
      guard_q <= npp_pkg::CODE_PROTECT_RST;
    end else begin
      unique case (state_r)
        npp_pkg::ST_LOAD: begin
          part_q <= nv_partition_image;
          guard_q <= nv_guard_image;
          state_r <= npp_pkg::ST_RUN;
        end
        npp_pkg::ST_RUN: begin
          if (bulk_erase) begin
            part_q <= npp_pkg::PARTITION_CFG_RST;
            guard_q <= npp_pkg::CODE_PROTECT_RST;
          end else if (cfg_wr_part && !cfg_refused)
            part_q <= part_nxt;
          else if (cfg_wr_guard && !cfg_refused)
            guard_q <= guard_nxt;  // takes effect next cycle
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // continuous decode of the partition
  // ---------------------------------------------------------------
  assign config_loaded = state_r == npp_pkg::ST_RUN;
  assign storage_area_active = !part_q.storage_area_enable_n;
  assign boot_region_active = !part_q.boot_region_enable_n;
  assign boot_end_addr = boot_region_active ? boot_end_f(part_q.boot_region_size) : 16'h0000;
  assign program_flash_read_guard = !guard_q.program_flash_read_guard;
  assign eeprom_read_guard = !guard_q.eeprom_read_guard;

  // ---------------------------------------------------------------
  // memory controller write check
  // ---------------------------------------------------------------
  npp_pkg::npp_region_e wr_rgn;
  logic wr_allow, err_clear;

  assign wr_rgn = region_of(nvm_wr_addr, part_q, boot_end_addr);
  assign err_clear = bus_wr && avs_address == npp_pkg::OFS_STATUS && avs_byteenable[0]
                     && avs_writedata[npp_pkg::STAT_WRITE_ERROR];

  // locks of disabled regions never apply: those addresses fall to the app region
  always_comb begin
    unique case (wr_rgn)
      npp_pkg::RGN_APP: wr_allow = part_q.application_region_write_lock;
      npp_pkg::RGN_BOOT: wr_allow = part_q.boot_region_write_lock;
      npp_pkg::RGN_SAF: wr_allow = part_q.storage_area_write_lock;
      npp_pkg::RGN_CFG: wr_allow = part_q.config_write_lock;
      npp_pkg::RGN_EE: wr_allow = part_q.eeprom_write_lock;
      default: wr_allow = 1'b0;
    endcase
  end

  // verdict one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      nvm_wr_done <= 1'b0;
      nvm_wr_ok <= 1'b0;
    end else begin
      nvm_wr_done <= nvm_wr_req && config_loaded;
      nvm_wr_ok <= nvm_wr_req && config_loaded && wr_allow;
    end
  end

  // sticky error; a new refusal wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s)
      write_error_flag <= 1'b0;
    else if ((nvm_wr_req && config_loaded && !wr_allow) || cfg_refused)
      write_error_flag <= 1'b1;
    else if (err_clear)
      write_error_flag <= 1'b0;
  end

  // ---------------------------------------------------------------
  // fetch address: wrap, vectors and storage-area exec violation flag
  // ---------------------------------------------------------------
  logic [14:0] pc_wrapped;
  logic viol_sticky_r;

  assign pc_wrapped = pc_in & LAST_ADDR[npp_pkg::PC_W-1:0];

  // held at the reset vector until the configuration is loaded
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      fetch_addr <= npp_pkg::RESET_VECTOR;
      exec_violation <= 1'b0;
    end else if (!config_loaded) begin
      fetch_addr <= npp_pkg::RESET_VECTOR;
      exec_violation <= 1'b0;
    end else if (irq_vector_req) begin
      fetch_addr <= npp_pkg::IRQ_VECTOR;
      exec_violation <= 1'b0;
    end else begin
      fetch_addr <= pc_wrapped;
      exec_violation <= region_of({1'b0, pc_wrapped}, part_q, boot_end_addr) == npp_pkg::RGN_SAF;
    end
  end

  // software-visible record of a fetch into the storage area
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s)
      viol_sticky_r <= 1'b0;
    else if (exec_violation)
      viol_sticky_r <= 1'b1;
    else if (bus_wr && avs_address == npp_pkg::OFS_STATUS && avs_byteenable[0]
             && avs_writedata[npp_pkg::STAT_EXEC_VIOL])
      viol_sticky_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // read data, captured in the wait cycle, stands at the answer
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      npp_pkg::OFS_REVISION: rd_mux = {18'h00000, npp_pkg::REV_RSV_BITS, MAJOR_REV, MINOR_REV};
      npp_pkg::OFS_PART: rd_mux = {18'h00000, npp_pkg::PART_RSV_BITS, PART_CODE};
      npp_pkg::OFS_PARTITION_CFG: rd_mux = {16'h0000, part_q};
      npp_pkg::OFS_CODE_PROTECT_CFG: rd_mux = {30'h0000_0000, guard_q};
      npp_pkg::OFS_STATUS: begin
        rd_mux[npp_pkg::STAT_LOADED] = config_loaded;
        rd_mux[npp_pkg::STAT_WRITE_ERROR] = write_error_flag;
        rd_mux[npp_pkg::STAT_SAF_ACTIVE] = storage_area_active;
        rd_mux[npp_pkg::STAT_BOOT_ACTIVE] = boot_region_active;
        rd_mux[npp_pkg::STAT_EXEC_VIOL] = viol_sticky_r;
        rd_mux[npp_pkg::STAT_BOOT_END_LSB +: 16] = boot_end_addr;
      end
      default: rd_mux = 32'h0000_0000;  // unmapped and control read zero
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s)
      avs_readdata <= 32'h0000_0000;
    else if (bus_rd)
      avs_readdata <= rd_mux;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_saf_lock;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (nvm_wr_req && config_loaded && wr_rgn == npp_pkg::RGN_SAF && !part_q.storage_area_write_lock)
      |=> nvm_wr_done && !nvm_wr_ok && write_error_flag;
  endproperty
  a_saf_lock: assert property (p_saf_lock) else $error("storage area write not refused");

  property p_ee_lock;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (nvm_wr_req && config_loaded && wr_rgn == npp_pkg::RGN_EE) |=> nvm_wr_ok == $past(part_q.eeprom_write_lock);
  endproperty
  a_ee_lock: assert property (p_ee_lock) else $error("eeprom write verdict wrong");

  property p_cfg_lock;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (cfg_wr_part && !part_q.config_write_lock && !bulk_erase && config_loaded) |=> $stable(part_q) ##0 write_error_flag;
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("locked config word changed");

  property p_boot_lock;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (nvm_wr_req && config_loaded && !part_q.boot_region_enable_n && nvm_wr_addr <= boot_end_addr
     && !part_q.boot_region_write_lock) |=> nvm_wr_done && !nvm_wr_ok;
  endproperty
  a_boot_lock: assert property (p_boot_lock) else $error("boot write not refused");

  property p_app_ok;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (nvm_wr_req && config_loaded && wr_rgn == npp_pkg::RGN_APP && part_q.application_region_write_lock)
      |=> nvm_wr_ok;
  endproperty
  a_app_ok: assert property (p_app_ok) else $error("permitted app write refused");

  property p_boot_half;
    @(posedge ref_clk) disable iff (!rst_n_s)
    boot_region_active |-> boot_end_addr <= HALF_END && boot_end_addr >= npp_pkg::BOOT_END_111;
  endproperty
  a_boot_half: assert property (p_boot_half) else $error("boot end beyond half memory");

  property p_lock_sticky;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (config_loaded && !part_q.application_region_write_lock && !bulk_erase)
      |=> !part_q.application_region_write_lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("write lock released without erase");

  property p_size_frozen;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (config_loaded && !part_q.boot_region_enable_n && !bulk_erase) |=> $stable(part_q.boot_region_size);
  endproperty
  a_size_frozen: assert property (p_size_frozen) else $error("boot size changed while enabled");

  property p_lvp_hold;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (config_loaded && lvp_mode_r && part_q.low_voltage_programming_enable && !bulk_erase)
      |=> part_q.low_voltage_programming_enable;
  endproperty
  a_lvp_hold: assert property (p_lvp_hold) else $error("lvp enable cleared in lvp mode");

  property p_guard_sticky;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (config_loaded && program_flash_read_guard && !bulk_erase) |=> program_flash_read_guard [*2];
  endproperty
  a_guard_sticky: assert property (p_guard_sticky) else $error("code protection dropped");

  property p_irq_vector;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (config_loaded && irq_vector_req) |=> fetch_addr == npp_pkg::IRQ_VECTOR && !exec_violation;
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("interrupt vector missed");

  property p_wrap;
    @(posedge ref_clk) disable iff (!rst_n_s)
    (config_loaded && !irq_vector_req) |=> fetch_addr == ($past(pc_in) & LAST_ADDR[14:0]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("fetch address not wrapped");

endmodule

// File: nvm_partition_protect_config_tb.sv
`timescale 1ns/1ps
module nvm_partition_protect_config_tb;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic ref_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, lvp_pin = 0, wr_req = 0, irq = 0;
  logic [15:0] avs_address = 16'h0000, wr_addr = 16'h0000, boot_end;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
  logic [14:0] pc = 15'h0000, fetch_addr;
  logic avs_waitrequest, wr_done, wr_ok, err_flag, boot_on, pf_guard, ee_guard, exec_viol, saf_on, loaded;
  // stored configuration images, changed only while reset is held
  logic [15:0] nv_img = 16'h2F9F;
  logic [1:0] nv_grd = 2'h3;
  int error_cnt = 0, checks_done = 0;
  // at most one lock cleared per entry, with a write address and its expected verdict
  logic [15:0] cfg_v [8] = '{16'h2F1F, 16'h2F8F, 16'h278F, 16'h279F, 16'h2B9F, 16'h2E97, 16'h2E9F, 16'h2D9F};
  logic [15:0] adr_v [8] = '{16'h0100, 16'h1F80, 16'h1F80, 16'h1F80, 16'hF000, 16'h0100, 16'h0100, 16'h8007};
  logic ok_v [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  always #4 ref_clk = ~ref_clk;
  // identity values are arbitrary
  npp_config_top #(.PROG_WORDS(8192), .PART_CODE(12'h6B1), .MAJOR_REV(6'h05), .MINOR_REV(6'h0A)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nv_partition_image(nv_img), .nv_guard_image(nv_grd),
    .lvp_programming_pin(lvp_pin), .nvm_wr_req(wr_req), .nvm_wr_addr(wr_addr), .nvm_wr_done(wr_done),
    .nvm_wr_ok(wr_ok), .write_error_flag(err_flag), .pc_in(pc), .irq_vector_req(irq), .fetch_addr(fetch_addr),
    .exec_violation(exec_viol), .storage_area_active(saf_on), .boot_region_active(boot_on),
    .boot_end_addr(boot_end), .program_flash_read_guard(pf_guard), .eeprom_read_guard(ee_guard),
    .config_loaded(loaded));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // avalon cycle: held until waitrequest is seen low, data taken there
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      $display("unexpected at %0t: bus hang", $time);
      final_report();
    end
    rdata = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string m);
    bus(0, a, 16'h0000);
    chk(rdata[15:0], e, m);
  endtask
  // one-cycle write attempt, verdict one cycle later
  task automatic nvm(input logic [15:0] a, input logic e);
    wr_req <= 1;
    wr_addr <= a;
    @(posedge ref_clk);
    wr_req <= 0;
    @(negedge ref_clk);
    chk({15'h0, wr_done}, 16'h0001, "write done");
    chk({15'h0, wr_ok}, {15'h0, e}, "write verdict");
    chk({15'h0, err_flag}, {15'h0, !e}, "error flag");
    @(posedge ref_clk);
  endtask
  task automatic fetch(input logic [14:0] p, input logic i, input logic [14:0] e, input logic v);
    pc <= p;
    irq <= i;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk({1'b0, fetch_addr}, {1'b0, e}, "fetch address");
    chk({15'h0, exec_viol}, {15'h0, v}, "exec violation");
    @(posedge ref_clk);
  endtask
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    @(negedge ref_clk);
    chk({1'b0, fetch_addr}, 16'h0000, "fetch in reset");
    chk({15'h0, loaded}, 16'h0000, "not loaded in reset");
    repeat (2) @(posedge ref_clk);
    resetn <= 1;
    repeat (6) @(posedge ref_clk);
    chk({15'h0, loaded}, 16'h0001, "config loaded");
    rd(16'h8006, 16'h36B1, "part word");
    rd(16'h8005, 16'h214A, "revision word");
    rd(16'h8020, 16'h0000, "unmapped read");
    bus(1, 16'h8006, 16'h0000);
    rd(16'h8006, 16'h36B1, "part word kept");
    rd(16'h800A, 16'h2F9F, "loaded partition");
    $display("identity test done");
    // size code picked while disabled, enable in the same write
    for (int k = 3; k < 8; k++) begin
      bus(1, 16'h8010, 16'h0001);
      bus(1, 16'h800A, 16'h2F90 | 16'(k));
      chk(boot_end, (k == 3) ? 16'h0FFF : (16'h0200 << (7 - k)) - 16'h0001, "boot end");
      chk({15'h0, boot_on}, 16'h0001, "boot active");
    end
    bus(1, 16'h800A, 16'h2F9E);
    rd(16'h800A, 16'h2F97, "size and enable kept");
    bus(1, 16'h8010, 16'h0001);
    chk(boot_end, 16'h0000, "boot disabled");
    $display("boot test done");
    for (int i = 0; i < 8; i++) begin
      bus(1, 16'h8010, 16'h0001);
      bus(1, 16'h8011, 16'h0002);
      bus(1, 16'h800A, cfg_v[i]);
      nvm(adr_v[i], ok_v[i]);
    end
    bus(1, 16'h800A, 16'h2F1F);
    rd(16'h800A, 16'h2D9F, "locked config");
    $display("lock test done");
    bus(1, 16'h8010, 16'h0001);
    lvp_pin <= 1;
    repeat (3) @(posedge ref_clk);
    bus(1, 16'h800A, 16'h0F9F);
    rd(16'h800A, 16'h2F9F, "lvp kept");
    lvp_pin <= 0;
    repeat (3) @(posedge ref_clk);
    bus(1, 16'h800A, 16'h0F9F);
    rd(16'h800A, 16'h0F9F, "lvp cleared");
    bus(1, 16'h800B, 16'h0002);
    chk({14'h0, ee_guard, pf_guard}, 16'h0001, "program guard");
    bus(1, 16'h800B, 16'h0003);
    chk({14'h0, ee_guard, pf_guard}, 16'h0001, "guard kept");
    bus(1, 16'h800B, 16'h0000);
    chk({14'h0, ee_guard, pf_guard}, 16'h0003, "both guards");
    $display("guard test done");
    bus(1, 16'h800A, 16'h0F8F);
    chk({15'h0, saf_on}, 16'h0001, "storage active");
    fetch(15'h7FF5, 1'b0, 15'h1FF5, 1'b1);
    fetch(15'h1F7F, 1'b0, 15'h1F7F, 1'b0);
    fetch(15'h0123, 1'b1, 15'h0004, 1'b0);
    $display("fetch test done");
    // second reset in mid-run: new images must replace every earlier write
    resetn <= 0;
    nv_img <= 16'h2E97;
    nv_grd <= 2'h2;
    irq <= 0;
    repeat (2) @(posedge ref_clk);
    chk({15'h0, loaded}, 16'h0000, "reloading");
    resetn <= 1;
    repeat (6) @(posedge ref_clk);
    chk({15'h0, loaded}, 16'h0001, "loaded again");
    rd(16'h800A, 16'h2E97, "image loaded");
    chk(boot_end, 16'h01FF, "boot end from image");
    chk({15'h0, saf_on}, 16'h0000, "storage off from image");
    chk({14'h0, ee_guard, pf_guard}, 16'h0001, "guard from image");
    $display("reset test done");
    final_report();
  end
endmodule
